// File: core/gpio_ports.sv
`timescale 1ns/100ps
`include "gpio_map.svh"
// Behaviour
// - first port direction per four-bit half
// - second port direction per bit
// - third port: four inputs, four outputs
// - pull-ups off on output pins
// - port reads return pin levels
// - or/and/xor read pins, write latch
// - drive config bit 2 selects push-pull
// - reset or recovery: first port inputs
// - uart transmit overrides first port bit seven
// - one global second port drive mode
// - power-on: second port all inputs
// - second port or/and gates, edge detect
// - ir amplifier wins over comparator one
// - analog mode: input zero reads one
// - input one source feeds irq two
// - uart receive from input two
// - analog: input two feeds comparator two
// - irq zero source follows receive interrupt enable
// - analog: bit three shows recovery state
// - input three falling edge irq one
// - irq one single selected source
module gpio_ports (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_stop_recover, // stop-mode recovery pulse
  input wire gpio_pkg::gpio_bus_t i_bus,
  input wire gpio_pkg::gpio_op_t i_op, // operation qualifying a write
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_first_pin,
  output gpio_pkg::gpio_pin_t o_first,
  input wire logic [7:0] i_second_pin,
  output gpio_pkg::gpio_pin_t o_second,
  input wire logic [3:0] i_third_pin,
  output logic [3:0] o_third_out,
  input wire logic [7:0] i_uart_control,
  input wire logic [7:0] i_irq_config,
  input wire logic i_uart_txd,
  input wire logic i_uart_rx_irq,
  input wire logic i_uart_tx_empty,
  input wire logic i_baud_rate_generator_event,
  input wire logic i_comparator_one,
  input wire logic i_comparator_two,
  input wire logic i_ir_amp_out,
  input wire logic i_recovery_cond_n, // low while a recovery condition exists
  input wire logic [3:0] i_timer_out,
  input wire logic i_demod_mode,
  output logic o_uart_rxd,
  output logic o_second_or,
  output logic o_second_and,
  output logic o_second_edge,
  output logic o_timer_edge_src,
  output logic o_interrupt_request_zero,
  output logic o_interrupt_request_one,
  output logic o_interrupt_request_two
);
  // ********************
  // registers
  // ********************
  logic [7:0] first_latch_ff; // output latches
  logic [7:0] second_latch_ff;
  logic [3:0] third_latch_ff;
  logic [1:0] first_hdir_ff; // [1] upper, [0] lower; 1 = input
  logic [7:0] second_dir_ff; // 1 = input
  logic [2:0] fsel_ff; // function select
  logic [1:0] cfg_ff; // [1] first push-pull, [0] comp out
  logic [7:0] rdata_ff;
  logic [7:0] second_prev_ff; // edge detect history
  logic src2_prev_ff, src0_prev_ff, in3_prev_ff, rec_prev_ff;
  logic interrupt_request_zero_ff, interrupt_request_one_ff, interrupt_request_two_ff, sedge_ff;
  logic analog, wr_hit_first, wr_hit_second, wr_hit_third;
  logic [7:0] first_dir_out, first_drive, third_rd;
  logic src2, src0;
  logic [7:0] third_rmw; // full-width result, upper half lands in the latch

  // applies the cpu operation against the pin levels, not the latch
  function automatic logic [7:0] gpio_rmw(input gpio_pkg::gpio_op_t op, input logic [7:0] pin,
                                          input logic [7:0] wd);
    unique case (op)
      gpio_pkg::GPIO_OP_OR: gpio_rmw = pin | wd;
      gpio_pkg::GPIO_OP_AND: gpio_rmw = pin & wd;
      gpio_pkg::GPIO_OP_XOR: gpio_rmw = pin ^ wd;
      default: gpio_rmw = wd;
    endcase
  endfunction : gpio_rmw

  // edge selection from two config bits: rise, fall or both
  function automatic logic gpio_edge(input logic cur, input logic prev, input logic [7:0] cfg);
    gpio_edge = (cfg[`GPIO_IRQC_RISE_BIT] & cur & ~prev) | (cfg[`GPIO_IRQC_FALL_BIT] & ~cur & prev);
  endfunction : gpio_edge

  // ********************
  // decode
  // ********************
  assign analog = fsel_ff[`GPIO_FSEL_ANALOG_BIT];
  assign wr_hit_first = i_bus.wr && i_bus.addr == `GPIO_ADDR_FIRST_DATA;
  assign wr_hit_second = i_bus.wr && i_bus.addr == `GPIO_ADDR_SECOND_DATA;
  assign wr_hit_third = i_bus.wr && i_bus.addr == `GPIO_ADDR_THIRD_DATA;
  assign third_rmw = gpio_rmw(i_op, {o_third_out, i_third_pin}, i_bus.wdata);

  // ********************
  // configuration registers
  // ********************
  // direction of first port: reset and recovery both return to input
  always_ff @(posedge i_clock)
  begin
    if (i_srst || i_stop_recover)
      first_hdir_ff <= `GPIO_RST_FIRST_HDIR;
    else if (i_bus.wr && i_bus.addr == `GPIO_ADDR_FIRST_HDIR)
      first_hdir_ff <= {i_bus.wdata[`GPIO_HDIR_UPPER_BIT], i_bus.wdata[`GPIO_HDIR_LOWER_BIT]};
  end

  // second port direction; recovery does not touch it
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      second_dir_ff <= `GPIO_RST_SECOND_DIR;
    else if (i_bus.wr && i_bus.addr == `GPIO_ADDR_SECOND_DIR)
      second_dir_ff <= i_bus.wdata;
  end

  // function select, holds analog, ir amp and second port drive
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      fsel_ff <= `GPIO_RST_FSEL;
    else if (i_bus.wr && i_bus.addr == `GPIO_ADDR_THIRD_FSEL)
      fsel_ff <= i_bus.wdata[2:0];
  end

  // drive configuration, kept across recovery
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      cfg_ff <= `GPIO_RST_CFG;
    else if (i_bus.wr && i_bus.addr == `GPIO_ADDR_DRIVE_CFG)
      cfg_ff <= {i_bus.wdata[`GPIO_CFG_FIRST_PP_BIT], i_bus.wdata[`GPIO_CFG_COMPOUT_BIT]};
  end

  // ********************
  // output latches
  // ********************
  // latches start low so pins never glitch high on turning to output
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      first_latch_ff <= 8'h00;
      second_latch_ff <= 8'h00;
      third_latch_ff <= `GPIO_RST_THIRD_OUT;
    end
    else
    begin
      if (wr_hit_first)
        first_latch_ff <= gpio_rmw(i_op, i_first_pin, i_bus.wdata);
      if (wr_hit_second)
        second_latch_ff <= gpio_rmw(i_op, i_second_pin, i_bus.wdata);
      if (wr_hit_third)
        third_latch_ff <= third_rmw[7:4];
    end
  end

  // ********************
  // pin drive
  // ********************
  always_comb
  begin
    first_dir_out = {{4{~first_hdir_ff[1]}}, {4{~first_hdir_ff[0]}}};
    first_drive = first_latch_ff;
    if (i_uart_control[`GPIO_UART_TXEN_BIT])
      first_drive[7] = i_uart_txd; // reaches pin only if upper half is output
  end

  // open drain drives only the low level
  assign o_first.out = first_drive;
  assign o_first.oe = first_dir_out & (cfg_ff[1] ? 8'hff : ~first_drive);
  assign o_first.pullup_en = ~first_dir_out;
  assign o_second.out = second_latch_ff;
  assign o_second.oe = ~second_dir_ff & (fsel_ff[`GPIO_FSEL_P2OD_BIT] ? 8'hff : ~second_latch_ff);
  assign o_second.pullup_en = second_dir_ff;

  // upper third port always pushes; timers OR into the latch, comparators may take over bits zero and three
  always_comb
  begin
    o_third_out = third_latch_ff | i_timer_out;
    if (cfg_ff[0])
    begin
      o_third_out[0] = fsel_ff[`GPIO_FSEL_IRAMP_BIT] ? i_ir_amp_out : i_comparator_one;
      o_third_out[3] = i_comparator_two;
    end
  end

  // ********************
  // third port input functions
  // ********************
  // ir amplifier takes precedence over comparator one
  assign src2 = fsel_ff[`GPIO_FSEL_IRAMP_BIT] ? i_ir_amp_out
              : (analog ? i_comparator_one : i_third_pin[1]);
  assign o_timer_edge_src = src2;
  assign o_uart_rxd = i_uart_control[`GPIO_UART_RXEN_BIT] ? i_third_pin[2] : 1'b1;
  // receive interrupt enable set routes the uart interrupt; polarity is a choice
  assign src0 = i_uart_control[`GPIO_UART_RXIE_BIT] ? i_uart_rx_irq
              : (analog ? i_comparator_two : i_third_pin[2]);

  // ********************
  // read path: pins, never latches
  // ********************
  always_comb
  begin
    third_rd = {4'hf, i_third_pin};
    if (analog)
    begin
      third_rd[0] = 1'b1;
      third_rd[3] = i_recovery_cond_n;
    end
  end

  // unmapped or write-only addresses read all ones
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      rdata_ff <= 8'h00;
    else if (i_bus.rd)
      unique case (i_bus.addr)
        `GPIO_ADDR_FIRST_DATA: rdata_ff <= i_first_pin;
        `GPIO_ADDR_SECOND_DATA: rdata_ff <= i_second_pin;
        `GPIO_ADDR_THIRD_DATA: rdata_ff <= third_rd;
        default: rdata_ff <= 8'hff;
      endcase
    else
      rdata_ff <= 8'h00;
  end
  assign o_rdata = rdata_ff;

  // ********************
  // second port wake logic
  // ********************
  assign o_second_or = |i_second_pin;
  assign o_second_and = &i_second_pin;
  // bit zero edge only in demodulation mode, any bit otherwise
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      second_prev_ff <= i_second_pin; // no false edge after reset
      sedge_ff <= 1'b0;
    end
    else
    begin
      second_prev_ff <= i_second_pin;
      sedge_ff <= i_demod_mode ? (i_second_pin[0] ^ second_prev_ff[0])
                               : |(i_second_pin ^ second_prev_ff);
    end
  end
  assign o_second_edge = sedge_ff;

  // ********************
  // interrupt request edges
  // ********************
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      // history follows the live level so release brings no false edge
      src2_prev_ff <= src2;
      src0_prev_ff <= src0;
      in3_prev_ff <= i_third_pin[3];
      rec_prev_ff <= i_recovery_cond_n;
      interrupt_request_zero_ff <= 1'b0;
      interrupt_request_one_ff <= 1'b0;
      interrupt_request_two_ff <= 1'b0;
    end
    else
    begin
      src2_prev_ff <= src2;
      src0_prev_ff <= src0;
      in3_prev_ff <= i_third_pin[3];
      rec_prev_ff <= i_recovery_cond_n;
      interrupt_request_two_ff <= gpio_edge(src2, src2_prev_ff, i_irq_config);
      interrupt_request_zero_ff <= gpio_edge(src0, src0_prev_ff, i_irq_config);
      // only one irq one source active at a time
      if (i_uart_control[`GPIO_UART_TXEN_BIT] && i_uart_control[`GPIO_UART_IEN_BIT])
        interrupt_request_one_ff <= i_uart_tx_empty;
      else if (i_uart_control[`GPIO_UART_BAUD_BIT] && i_uart_control[`GPIO_UART_IEN_BIT]
               && !i_uart_control[`GPIO_UART_RXEN_BIT])
        interrupt_request_one_ff <= i_baud_rate_generator_event;
      else if (analog)
        interrupt_request_one_ff <= rec_prev_ff & ~i_recovery_cond_n;
      else
        interrupt_request_one_ff <= in3_prev_ff & ~i_third_pin[3];
    end
  end
  assign o_interrupt_request_zero = interrupt_request_zero_ff;
  assign o_interrupt_request_one = interrupt_request_one_ff;
  assign o_interrupt_request_two = interrupt_request_two_ff;

  // ********************
  // checks
  // ********************
  AST_FIRST_RECOVER_INPUT: assert property (@(posedge i_clock)
    i_stop_recover |=> o_first.oe == 8'h00) else $error("first port drives after recovery");
  AST_PULLUP_OFF_OUT: assert property (@(posedge i_clock) disable iff (i_srst)
    (o_first.pullup_en & o_first.oe) == 8'h00 && (o_second.pullup_en & o_second.oe) == 8'h00)
    else $error("pull-up on while driving");
  AST_HALF_DIR: assert property (@(posedge i_clock) disable iff (i_srst)
    o_first.pullup_en[3:0] == {4{o_first.pullup_en[0]}}) else $error("lower half split");
  AST_FIRST_READ_PIN: assert property (@(posedge i_clock) disable iff (i_srst)
    i_bus.rd && i_bus.addr == `GPIO_ADDR_FIRST_DATA |=> o_rdata == $past(i_first_pin))
    else $error("first port read not pin level");
  AST_ANALOG_BIT0: assert property (@(posedge i_clock) disable iff (i_srst)
    i_bus.rd && i_bus.addr == `GPIO_ADDR_THIRD_DATA && analog |=> o_rdata[0])
    else $error("analog bit zero not one");
  AST_SECOND_POR: assert property (@(posedge i_clock)
    i_srst |=> o_second.oe == 8'h00) else $error("second port drives after reset");
  AST_IR_WINS: assert property (@(posedge i_clock) disable iff (i_srst)
    fsel_ff[`GPIO_FSEL_IRAMP_BIT] |-> o_timer_edge_src == i_ir_amp_out) else $error("ir amp not selected");
  AST_OR_GATE: assert property (@(posedge i_clock) disable iff (i_srst)
    o_second_or == (i_second_pin != 8'h00)) else $error("or gate wrong");
endmodule : gpio_ports

// File: core/gpio_map.svh
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH
// ********************
// register offsets
// ********************
`define GPIO_ADDR_FIRST_DATA 12'h000
`define GPIO_ADDR_SECOND_DATA 12'h002
`define GPIO_ADDR_THIRD_DATA 12'h003
`define GPIO_ADDR_SECOND_DIR 12'h0f6
`define GPIO_ADDR_THIRD_FSEL 12'h0f7
`define GPIO_ADDR_FIRST_HDIR 12'h0f8
`define GPIO_ADDR_DRIVE_CFG 12'hf00
// ********************
// field positions
// ********************
`define GPIO_HDIR_UPPER_BIT 6
`define GPIO_HDIR_LOWER_BIT 0
`define GPIO_FSEL_ANALOG_BIT 1
`define GPIO_FSEL_IRAMP_BIT 2
`define GPIO_FSEL_P2OD_BIT 0
`define GPIO_CFG_FIRST_PP_BIT 2
`define GPIO_CFG_COMPOUT_BIT 0
`define GPIO_UART_TXEN_BIT 7
`define GPIO_UART_RXEN_BIT 6
`define GPIO_UART_IEN_BIT 5
`define GPIO_UART_BAUD_BIT 0
`define GPIO_UART_RXIE_BIT 4
`define GPIO_IRQC_RISE_BIT 6
`define GPIO_IRQC_FALL_BIT 7
// ********************
// reset values
// ********************
`define GPIO_RST_SECOND_DIR 8'hff
`define GPIO_RST_FIRST_HDIR 2'b11
`define GPIO_RST_FSEL 3'b000
`define GPIO_RST_CFG 2'b10
`define GPIO_RST_THIRD_OUT 4'h0
`endif

// File: core/gpio_pkg.sv
package gpio_pkg;
  // ********************
  // register bus request
  // ********************
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gpio_bus_t;
  // ********************
  // one port's pin triple
  // ********************
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pullup_en;
  } gpio_pin_t;
  // read-modify-write operations of the cpu
  typedef enum logic [1:0] {GPIO_OP_STORE, GPIO_OP_OR, GPIO_OP_AND, GPIO_OP_XOR} gpio_op_t;
endpackage : gpio_pkg

// File: verification/gpio_pin_model.sv
`timescale 1ns/100ps
// ********************
// outside circuits on the two bidirectional ports
// ********************
module gpio_pin_model (
  input wire gpio_pkg::gpio_pin_t i_first,
  input wire gpio_pkg::gpio_pin_t i_second,
  input wire logic [7:0] i_ext_first, // outside level on the first port
  input wire logic [7:0] i_ext_second, // outside level on the second port
  output logic [7:0] o_first_pin,
  output logic [7:0] o_second_pin
);
  // a driven bit shows the port, a released bit the outside circuit
  // the outside driver beats the weak pull-up, so a floating pin never occurs
  function automatic logic [7:0] resolve(gpio_pkg::gpio_pin_t p, logic [7:0] ext);
    resolve = (p.oe & p.out) | (~p.oe & ext);
  endfunction : resolve
  assign o_first_pin = resolve(i_first, i_ext_first);
  assign o_second_pin = resolve(i_second, i_ext_second);
endmodule : gpio_pin_model

// File: verification/gpio_ports_bench.sv
`timescale 1ns/100ps
`include "gpio_map.svh"
module gpio_ports_bench;
  // ********************
  // stimulus, pins and counters
  // ********************
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic stop = 1'b0;
  gpio_pkg::gpio_bus_t i_bus = '0;
  gpio_pkg::gpio_op_t i_op = gpio_pkg::GPIO_OP_STORE;
  logic [7:0] o_rdata, fpin, spin, ext_f = 8'h00, ext_s = 8'h00, uart_ctl = 8'h00, irqc = 8'h00;
  logic [3:0] third = 4'hf, timer = 4'h0, o_third_out;
  logic txd = 1'b0, tx_empty = 1'b0, cmp1 = 1'b0, ir = 1'b0, rcn = 1'b1, rxd, s_or, s_and, tsrc, q0, q1, q2;
  gpio_pkg::gpio_pin_t o_first, o_second;
  int fails = 0, checked = 0, n0 = 0, n1 = 0, n2 = 0;
  initial forever #2.5 i_clock = ~i_clock;
  // irq pulses are one cycle, so one sample per edge counts each once
  always @(posedge i_clock)
  begin
    n0 += (q0 === 1'b1);
    n1 += (q1 === 1'b1);
    n2 += (q2 === 1'b1);
  end
  gpio_ports gpio_ports_i (.i_clock(i_clock), .i_srst(i_srst), .i_stop_recover(stop), .i_bus(i_bus),
    .i_op(i_op), .o_rdata(o_rdata), .i_first_pin(fpin), .o_first(o_first), .i_second_pin(spin),
    .o_second(o_second), .i_third_pin(third), .o_third_out(o_third_out), .i_uart_control(uart_ctl),
    .i_irq_config(irqc), .i_uart_txd(txd), .i_uart_rx_irq(1'b0), .i_uart_tx_empty(tx_empty),
    .i_baud_rate_generator_event(1'b0), .i_comparator_one(cmp1), .i_comparator_two(1'b0), .i_ir_amp_out(ir),
    .i_recovery_cond_n(rcn), .i_timer_out(timer), .i_demod_mode(1'b0), .o_uart_rxd(rxd),
    .o_second_or(s_or), .o_second_and(s_and), .o_second_edge(), .o_timer_edge_src(tsrc),
    .o_interrupt_request_zero(q0), .o_interrupt_request_one(q1), .o_interrupt_request_two(q2));
  gpio_pin_model gpio_pin_model_i (.i_first(o_first), .i_second(o_second), .i_ext_first(ext_f),
    .i_ext_second(ext_s), .o_first_pin(fpin), .o_second_pin(spin));
  // ********************
  // bus cycles and comparison
  // ********************
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [7:0] d, input gpio_pkg::gpio_op_t op = gpio_pkg::GPIO_OP_STORE);
    @(posedge i_clock);
    i_bus <= {a, d, 2'b10};
    i_op <= op;
    @(posedge i_clock);
    i_bus <= '0;
    #1;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_bus <= {a, 8'h00, 2'b01};
    @(posedge i_clock);
    i_bus <= '0;
    #1 d = o_rdata;
  endtask : rd
  // hold third pins at a, step to b, count pulses on one request line
  task irq(input int w, input logic [3:0] a, input logic [3:0] b, input int exp);
    int base;
    @(posedge i_clock) third <= a;
    repeat (3) @(posedge i_clock);
    base = (w == 0) ? n0 : (w == 1) ? n1 : n2;
    third <= b;
    repeat (4) @(posedge i_clock);
    chk(8'(((w == 0) ? n0 : (w == 1) ? n1 : n2) - base), 8'(exp));
  endtask : irq
  function automatic logic [7:0] rmw(int op, logic [7:0] p, logic [7:0] k);
    rmw = (op == 1) ? (p | k) : (op == 2) ? (p & k) : (op == 3) ? (p ^ k) : k;
  endfunction : rmw
  task test_done;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // watchdog: the tests need well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge i_clock);
    fails++;
    test_done;
  end
  // ********************
  // main sequence
  // ********************
  initial
  begin
    logic [7:0] d, e, v, l;
    void'($urandom(32'h6572fb7e));
    repeat (10) @(posedge i_clock);
    i_srst <= 1'b0;
    #1 chk(o_first.oe, 8'h00);
    chk(o_second.oe, 8'h00);
    rd(`GPIO_ADDR_SECOND_DIR, d);
    chk(d, 8'hff);
    rd(12'h0f0, d);
    chk(d, 8'hff);
    wr(`GPIO_ADDR_FIRST_HDIR, 8'h40);
    chk(o_first.oe, 8'h0f);
    chk(o_first.pullup_en, 8'hf0);
    wr(`GPIO_ADDR_FIRST_HDIR, 8'h01);
    chk(o_first.oe, 8'hf0);
    @(posedge i_clock) stop <= 1'b1;
    @(posedge i_clock) stop <= 1'b0;
    #1 chk(o_first.oe, 8'h00);
    $display("test direction done");
    // second port push-pull, random direction and data against outside levels
    wr(`GPIO_ADDR_THIRD_FSEL, 8'h01);
    repeat (4)
    begin
      d = 8'($urandom);
      v = 8'($urandom);
      ext_s <= 8'($urandom);
      wr(`GPIO_ADDR_SECOND_DIR, d);
      chk(o_second.oe, ~d);
      chk(o_second.pullup_en, d);
      wr(`GPIO_ADDR_SECOND_DATA, v);
      rd(`GPIO_ADDR_SECOND_DATA, e);
      chk(e, (~d & v) | (d & ext_s));
    end
    // open-drain first port: a high latch releases the pin to the outside level
    wr(`GPIO_ADDR_DRIVE_CFG, 8'h00);
    wr(`GPIO_ADDR_FIRST_HDIR, 8'h00);
    l = 8'h00; // latches come out of reset low
    for (int op = 3; op >= 0; op--)
    begin
      e = 8'($urandom);
      v = 8'($urandom);
      ext_f <= e;
      wr(`GPIO_ADDR_FIRST_DATA, v, gpio_pkg::gpio_op_t'(op));
      l = rmw(op, l & e, v);
      chk(o_first.oe, ~l);
    end
    wr(`GPIO_ADDR_DRIVE_CFG, 8'h04);
    chk(o_first.oe, 8'hff);
    for (int t = 0; t < 2; t++)
    begin
      @(posedge i_clock) uart_ctl <= 8'h80;
      txd <= t[0];
      #1 chk(8'(o_first.out[7]), 8'(t[0]));
    end
    $display("test first port done");
    uart_ctl <= 8'h00;
    wr(`GPIO_ADDR_THIRD_DATA, 8'ha0);
    chk(8'(o_third_out), 8'h0a);
    @(posedge i_clock) timer <= 4'h1;
    #1 chk(8'(o_third_out), 8'h0b);
    wr(`GPIO_ADDR_SECOND_DIR, 8'hff);
    for (int i = 0; i < 6; i++)
    begin
      e = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      @(posedge i_clock) ext_s <= e;
      #1 chk(8'({s_or, s_and}), 8'({|e, &e}));
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(`GPIO_ADDR_THIRD_FSEL, 8'({i[1:0], 1'b1}));
      third <= 4'($urandom);
      cmp1 <= i[2];
      ir <= ~i[2];
      uart_ctl <= {1'b0, i[0], 6'h00};
      @(posedge i_clock) #1;
      chk(8'(tsrc), 8'(i[1] ? ir : i[0] ? cmp1 : third[1]));
      chk(8'(rxd), 8'(i[0] ? third[2] : 1'b1));
    end
    rcn <= 1'b0;
    rd(`GPIO_ADDR_THIRD_DATA, d);
    chk(8'({d[3], d[0]}), 8'h01);
    $display("test third port done");
    // digital mode edges; the last irq one check switches to analog, where input three no longer feeds it
    wr(`GPIO_ADDR_THIRD_FSEL, 8'h01);
    uart_ctl <= 8'h00;
    irqc <= 8'h80;
    irq(1, 4'hf, 4'h7, 1);
    irq(2, 4'hf, 4'hd, 1);
    irqc <= 8'h40;
    irq(0, 4'h0, 4'h4, 1);
    uart_ctl <= 8'h10;
    irq(0, 4'h0, 4'h4, 0);
    uart_ctl <= 8'ha0;
    irq(1, 4'hf, 4'h7, 0);
    uart_ctl <= 8'h00;
    wr(`GPIO_ADDR_THIRD_FSEL, 8'h03);
    irq(1, 4'hf, 4'h7, 0);
    $display("test interrupts done");
    test_done;
  end
endmodule : gpio_ports_bench
